// file: hdl/dpsm_defines.svh
`ifndef DPSM_DEFINES_SVH
`define DPSM_DEFINES_SVH

// ----------------------------------------------------------------
// clock and device timing, in ns
// ----------------------------------------------------------------
`define DPSM_CLK_PERIOD_NS          10  // ref_clk period
`define DPSM_SEM_UPDATE_PULSE_NS    10  // strobes off after a semaphore write
`define DPSM_SEM_WRITE_TO_READ_NS   5   // extra wait before the read strobe

// ----------------------------------------------------------------
// address layout
// ----------------------------------------------------------------
`define DPSM_ADDR_W                 14       // device address width
`define DPSM_DATA_W                 8        // device data width
`define DPSM_SEM_IDX_W              3        // semaphore index width
`define DPSM_SEM_COUNT              8        // number of semaphore latches
`define DPSM_MBOX_LEFT_ADDR         14'h3FFE // flag of the left port
`define DPSM_MBOX_RIGHT_ADDR        14'h3FFF // flag of the right port
`define DPSM_SEM_FREE_BIT           1'h1     // value that frees a semaphore
`define DPSM_SEM_TAKE_BIT           1'h0     // value that requests a semaphore

`endif

// file: hdl/dpsm_pkg.sv
`default_nettype none

package dpsm_pkg;

    // ------------------------------------------------------------
    // commands taken on the user port
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DPSM_OP_MEM_RD    = 3'h0, // plain memory read
        DPSM_OP_MEM_WR    = 3'h1, // plain memory write
        DPSM_OP_SEM_ACQ   = 3'h2, // request semaphore, poll until owned
        DPSM_OP_SEM_REL   = 3'h3, // release semaphore
        DPSM_OP_SEM_INIT  = 3'h4, // write one to every semaphore
        DPSM_OP_MBOX_POST = 3'h5, // write partner mailbox word
        DPSM_OP_MBOX_READ = 3'h6  // read own mailbox word, clears flag
    } dpsm_op_t;

    // ------------------------------------------------------------
    // sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        DPSM_ST_IDLE  = 6'h01, // waiting for a command
        DPSM_ST_SETUP = 6'h02, // address out, busy settling
        DPSM_ST_WRITE = 6'h04, // write strobe low
        DPSM_ST_RECOV = 6'h08, // strobes off between semaphore accesses
        DPSM_ST_READ  = 6'h10, // output enable low, data settling
        DPSM_ST_DONE  = 6'h20  // answer presented
    } dpsm_state_t;

endpackage

`default_nettype wire

// file: hdl/dpsm_host_port.sv
// ----------------------------------------------------------------
// Summary of operation
// R1: device grants one port on contention
// R2: close races still grant one port
// R3: busy follows match or enable fixed delay
// R4: master drives busy lines as outputs
// R5: hold writes until busy has settled
// R6: slave blocks writes while busy asserted
// R7: eight shared semaphore latches exist
// R8: write zero, read back, poll on one
// R9: strobes off update pulse before readback
// R10: semaphore select low, chip enable high
// R11: semaphore index is three low address bits
// R12: semaphore write uses data bit zero
// R13: taker reads zero, other side reads one
// R14: owner writing one frees semaphore
// R15: pending request wins on release
// R16: repeated zero leaves ownership unchanged
// R17: semaphore read drives all data lines
// R18: semaphore read value held stable
// R19: simultaneous requests give single owner
// R20: software writes one to all semaphores
// R21: left write at top sets right flag
// R22: right write below top sets left flag
// ----------------------------------------------------------------

`include "dpsm_defines.svh"

`default_nettype none

module dpsm_host_port
    import dpsm_pkg::*;
#(
    parameter bit IS_LEFT        = 1'b1, // this controller drives the left port
    parameter int ADDR_TO_BUSY_NS = 15,  // busy settle after address
    parameter int OE_ACCESS_NS    = 15,  // output enable to data valid
    parameter int WRITE_PULSE_NS  = 15   // write strobe width
)
(
    input  wire logic                     ref_clk,     // system clock
    input  wire logic                     sys_rst,     // synchronous reset
    input  wire logic                     cmd_valid,   // command offered
    input  wire dpsm_op_t                 cmd_op,      // command code
    input  wire logic [`DPSM_ADDR_W-1:0]  cmd_addr,    // memory addr / sem index
    input  wire logic [`DPSM_DATA_W-1:0]  cmd_wdata,   // write data
    output var  logic                     cmd_ready,   // command taken when high
    output var  logic                     rsp_valid,   // one-cycle answer pulse
    output var  logic [`DPSM_DATA_W-1:0]  rsp_rdata,   // read data
    output var  logic                     rsp_granted, // semaphore owned
    output var  logic                     mbox_flag,   // own mailbox flag set
    output var  logic                     ce_n,        // chip enable, low
    output var  logic                     sem_n,       // semaphore select, low
    output var  logic                     oe_n,        // output enable, low
    output var  logic                     rw_n,        // low for write
    output var  logic [`DPSM_ADDR_W-1:0]  addr,        // address pins
    output var  logic [`DPSM_DATA_W-1:0]  dq_o,        // data pins out
    output var  logic                     dq_oe_n,     // low while driving dq
    input  wire logic [`DPSM_DATA_W-1:0]  dq_i,        // data pins in
    input  wire logic                     busy_n,      // busy from device, low
    input  wire logic                     int_n        // mailbox flag, low
);

    // ------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------
    // least times round up, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + `DPSM_CLK_PERIOD_NS - 1) / `DPSM_CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [3:0] SETTLE_CYC = 4'(ns_to_cyc(ADDR_TO_BUSY_NS));
    localparam logic [3:0] ACCESS_CYC = 4'(ns_to_cyc(OE_ACCESS_NS));
    localparam logic [3:0] PULSE_CYC  = 4'(ns_to_cyc(WRITE_PULSE_NS));
    localparam logic [3:0] GAP_CYC    = 4'(ns_to_cyc(`DPSM_SEM_UPDATE_PULSE_NS
                                                     + `DPSM_SEM_WRITE_TO_READ_NS));

    // own flag and the partner's flag sit at fixed top addresses
    localparam logic [`DPSM_ADDR_W-1:0] OWN_MBOX  =
        IS_LEFT ? `DPSM_MBOX_LEFT_ADDR : `DPSM_MBOX_RIGHT_ADDR;
    localparam logic [`DPSM_ADDR_W-1:0] PEER_MBOX =
        IS_LEFT ? `DPSM_MBOX_RIGHT_ADDR : `DPSM_MBOX_LEFT_ADDR;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dpsm_state_t                state_r;    // sequencer
    dpsm_state_t                state_nxt;  // its next value
    dpsm_op_t                   op_r;       // latched command
    logic [`DPSM_ADDR_W-1:0]    addr_r;     // latched address
    logic [`DPSM_DATA_W-1:0]    wdata_r;    // latched write data
    logic [3:0]                 cnt_r;      // wait counter
    logic [3:0]                 cnt_nxt;    // its next value
    logic [`DPSM_SEM_IDX_W-1:0] idx_r;      // init walk index
    logic [`DPSM_DATA_W-1:0]    rdata_r;    // captured read data

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire accept    = cmd_valid && cmd_ready;
    wire dpsm_op_t op_nxt = accept ? cmd_op : op_r;
    wire is_sem    = (op_r == DPSM_OP_SEM_ACQ) || (op_r == DPSM_OP_SEM_REL)
                     || (op_r == DPSM_OP_SEM_INIT);
    wire is_sem_nx = (op_nxt == DPSM_OP_SEM_ACQ) || (op_nxt == DPSM_OP_SEM_REL)
                     || (op_nxt == DPSM_OP_SEM_INIT);
    wire is_write  = (op_r != DPSM_OP_MEM_RD) && (op_r != DPSM_OP_MBOX_READ);
    wire cnt_done  = (cnt_r == 4'h1);
    wire last_sem  = (idx_r == `DPSM_SEM_IDX_W'(`DPSM_SEM_COUNT - 1));
    wire sem_taken = (rdata_r[0] == `DPSM_SEM_TAKE_BIT);   // R8
    wire sem_lost  = (dq_i[0] != `DPSM_SEM_TAKE_BIT);      // R8

    // latched address for the chosen command
    wire [`DPSM_ADDR_W-1:0] addr_sel =
        (cmd_op == DPSM_OP_MBOX_POST) ? PEER_MBOX :         // R21 R22
        (cmd_op == DPSM_OP_MBOX_READ) ? OWN_MBOX  :         // R21 R22
        cmd_addr;

    // semaphore data carries one bit, upper lines zero
    wire [`DPSM_DATA_W-1:0] sem_wdata =
        (op_nxt == DPSM_OP_SEM_ACQ) ? `DPSM_DATA_W'(`DPSM_SEM_TAKE_BIT)
                                    : `DPSM_DATA_W'(`DPSM_SEM_FREE_BIT); // R20

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r > 4'h1) ? cnt_r - 4'h1 : cnt_r;
        case (state_r)
            DPSM_ST_IDLE:
            begin
                // address and select go out, busy gets time to settle;
                // only a taken command moves on, else op_r would be stale
                if (accept)
                begin
                    state_nxt = DPSM_ST_SETUP;
                    cnt_nxt   = SETTLE_CYC;                   // R5
                end
            end
            DPSM_ST_SETUP:
            begin
                // memory access waits out an asserted busy
                if (cnt_done && (is_sem || busy_n))           // R5
                begin
                    state_nxt = is_write ? DPSM_ST_WRITE : DPSM_ST_READ;
                    cnt_nxt   = is_write ? PULSE_CYC : ACCESS_CYC;
                end
            end
            DPSM_ST_WRITE:
            begin
                // an acquire goes on to read back its latch
                if (cnt_done)
                begin
                    state_nxt = (op_r == DPSM_OP_SEM_ACQ) ? DPSM_ST_RECOV
                                                          : DPSM_ST_DONE;
                    cnt_nxt   = GAP_CYC;                      // R9
                end
            end
            DPSM_ST_RECOV:
            begin
                if (cnt_done)
                begin
                    state_nxt = DPSM_ST_READ;                 // R9
                    cnt_nxt   = ACCESS_CYC;
                end
            end
            DPSM_ST_READ:
            begin
                if (cnt_done)
                begin
                    // reading one means the other side owns it: poll again
                    if ((op_r == DPSM_OP_SEM_ACQ) && sem_lost) // R8
                    begin
                        state_nxt = DPSM_ST_RECOV;
                        cnt_nxt   = GAP_CYC;
                    end
                    else
                    begin
                        state_nxt = DPSM_ST_DONE;
                    end
                end
            end
            DPSM_ST_DONE:
            begin
                // init walks every latch before answering
                if ((op_r == DPSM_OP_SEM_INIT) && !last_sem) // R20
                begin
                    state_nxt = DPSM_ST_SETUP;
                    cnt_nxt   = SETTLE_CYC;
                end
                else
                begin
                    state_nxt = DPSM_ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = DPSM_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // pin next values
    // ------------------------------------------------------------
    wire active_nx = (state_nxt == DPSM_ST_SETUP) || (state_nxt == DPSM_ST_WRITE)
                     || (state_nxt == DPSM_ST_READ);
    wire ce_n_nxt  = !(active_nx && !is_sem_nx);          // R10
    wire sem_n_nxt = !(active_nx && is_sem_nx);           // R10
    wire init_step = (state_r == DPSM_ST_DONE) && (state_nxt == DPSM_ST_SETUP);
    // walk index restarts with every taken command, so a second init starts at zero
    wire [`DPSM_SEM_IDX_W-1:0] idx_nxt = accept ? `DPSM_SEM_IDX_W'(0)
                                       : init_step ? idx_r + `DPSM_SEM_IDX_W'(1) : idx_r;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // control and pins; pins switch with the state so they come from flops
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_r     <= DPSM_ST_IDLE;
            cnt_r       <= 4'h0;
            op_r        <= DPSM_OP_MEM_RD;
            idx_r       <= `DPSM_SEM_IDX_W'(0);
            cmd_ready   <= 1'b0;
            rsp_valid   <= 1'b0;
            rsp_granted <= 1'b0;
            ce_n        <= 1'b1;
            sem_n       <= 1'b1;
            oe_n        <= 1'b1;
            rw_n        <= 1'b1;
            dq_oe_n     <= 1'b1;
            mbox_flag   <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            op_r        <= op_nxt;
            idx_r       <= idx_nxt;
            cmd_ready   <= (state_nxt == DPSM_ST_IDLE) && !accept;
            rsp_valid   <= (state_nxt == DPSM_ST_IDLE) && (state_r == DPSM_ST_DONE);
            rsp_granted <= (state_r == DPSM_ST_DONE) && (op_r == DPSM_OP_SEM_ACQ)
                           && sem_taken;                  // R8
            ce_n        <= ce_n_nxt;
            sem_n       <= sem_n_nxt;
            oe_n        <= !(state_nxt == DPSM_ST_READ);
            rw_n        <= !(state_nxt == DPSM_ST_WRITE);
            dq_oe_n     <= !(state_nxt == DPSM_ST_WRITE);
            mbox_flag   <= !int_n;
        end
    end

    // data path: no reset needed, qualified by the strobes
    always_ff @(posedge ref_clk)
    begin
        if (accept)
        begin
            addr_r  <= addr_sel;
            wdata_r <= is_sem_nx ? sem_wdata : cmd_wdata; // R12
        end
        if ((state_r == DPSM_ST_READ) && cnt_done)
        begin
            rdata_r <= dq_i;
        end
        addr    <= (is_sem_nx && (op_nxt == DPSM_OP_SEM_INIT))
                   ? `DPSM_ADDR_W'(idx_nxt)
                   : (accept ? addr_sel : addr_r);        // R11 R20
        dq_o    <= accept ? (is_sem_nx ? sem_wdata : cmd_wdata) : wdata_r;
        rsp_rdata <= rdata_r;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sem_select_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R10
        !sem_n |-> ce_n)
        else $error("semaphore select low with chip enable low");

    busy_settle_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
        ($fell(rw_n) && !ce_n) |-> $past(busy_n) && $past(!ce_n, 2))
        else $error("memory write started before busy settled");

    sem_gap_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R9
        ($rose(rw_n) && $past(!sem_n)) |-> (sem_n || oe_n) [*2])
        else $error("semaphore read started too soon after write");

    sem_grant_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R8
        (rsp_valid && (op_r == DPSM_OP_SEM_ACQ)) |-> rsp_granted && !rsp_rdata[0])
        else $error("acquire answered without reading zero");

    sem_data_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R12
        (!rw_n && !sem_n) |-> (dq_o[7:1] == 7'h00) && !dq_oe_n)
        else $error("semaphore write drives upper data lines");

    init_ones_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R20
        (!rw_n && !sem_n && (op_r == DPSM_OP_SEM_INIT)) |-> dq_o[0])
        else $error("init wrote a zero to a semaphore");

endmodule

`default_nettype wire

// file: bench/dpsm_dev_model.sv
`default_nettype none

module dpsm_dev_model
(
    input  wire logic        ref_clk, // sampling clock
    input  wire logic        ce_n,    // left enable
    input  wire logic        sem_n,   // left sem select
    input  wire logic        oe_n,    // left read
    input  wire logic        rw_n,    // left write, low
    input  wire logic [13:0] addr,    // left address
    input  wire logic [7:0]  l_dq,    // left data in
    input  wire logic        dq_oe_n, // left drives dq
    output var  logic [7:0]  dq_i,    // left data out
    output var  logic        busy_n,  // left busy
    output var  logic        int_n,   // left flag
    input  wire logic        r_ce_n,  // right enable
    input  wire logic        r_sem_n, // right sem select
    input  wire logic        r_oe_n,  // right read
    input  wire logic        r_rw_n,  // right write, low
    input  wire logic [13:0] r_addr,  // right address
    input  wire logic [7:0]  r_wdata, // right data in
    output var  logic [7:0]  r_rdata, // right data out
    output var  logic        r_int_n  // right flag
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------
    // state, behavioural and sampled on ref_clk
    // ------------------------------------------------
    logic [7:0]  mem  [0:16383]; // array
    logic [1:0]  own  [0:7];     // 0 free, 1 left, 2 right
    logic [1:0]  pend [0:7];     // waiting request, bit per side
    logic [13:0] aq   [1:2];     // address seen while selected
    logic [7:0]  dq   [1:2];     // data seen while writing
    logic [1:2]  smq, wp, rp;    // sem access, write, read last cycle
    logic        r_first = 1'b0; // right selected before left
    logic        il = 1'b0;      // left mailbox flag
    logic        ir = 1'b0;      // right mailbox flag
    wire  [1:2]  wr = {!rw_n && (!ce_n || !sem_n), !r_rw_n && (!r_ce_n || !r_sem_n)};
    wire  [1:2]  rd = {!oe_n && rw_n && (!ce_n || !sem_n), !r_oe_n && r_rw_n && (!r_ce_n || !r_sem_n)};
    // busy appears at once: the fastest answer a controller may meet
    assign busy_n  = !(!ce_n && !r_ce_n && addr == r_addr && r_first);
    assign int_n   = !il;
    assign r_int_n = !ir;
    initial
    begin
        // no power-up reset: latches start owned, not free
        for (int i = 0; i < 8; i++) own[i] = 2'h1;
        for (int i = 0; i < 8; i++) pend[i] = 2'h0;
        {wp, rp, smq, dq_i, r_rdata} = '0;
    end
    // write commit on the rising edge of the write
    task automatic acc(input int s);
        logic [2:0] i;
        i = aq[s][2:0];
        if (!smq[s])
        begin
            mem[aq[s]] = dq[s];
            if (s == 1 && aq[s] == 14'h3FFF) ir = 1'b1;
            if (s == 2 && aq[s] == 14'h3FFE) il = 1'b1;
        end
        else if (!dq[s][0])
        begin
            if (own[i] == 2'h0) own[i] = 2'(s);
            else if (own[i] != 2'(s)) pend[i][s-1] = 1'b1;
        end
        else if (own[i] == 2'(s))
        begin
            own[i] = pend[i][2-s] ? 2'(3 - s) : 2'h0;
            pend[i][2-s] = 1'b0;
        end
        else pend[i][s-1] = 1'b0; // cancel own request
    endtask
    function automatic logic [7:0] rv(input int s);
        if (smq[s]) return {8{own[aq[s][2:0]] != 2'(s)}};
        return mem[aq[s]];
    endfunction
    // ------------------------------------------------
    // port sampling, left handled first so a tie has one owner
    // ------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (ce_n) r_first = !r_ce_n;
        if (!ce_n || !sem_n) {aq[1], smq[1]} = {addr, !sem_n};
        if (!r_ce_n || !r_sem_n) {aq[2], smq[2]} = {r_addr, !r_sem_n};
        if (!dq_oe_n) dq[1] = l_dq;
        if (wr[2]) dq[2] = r_wdata;
        for (int s = 1; s <= 2; s++)
            if (wp[s] && !wr[s]) acc(s);
        if (rd[1] && !rp[1] && !smq[1] && aq[1] == 14'h3FFE) il = 1'b0;
        if (rd[2] && !rp[2] && !smq[2] && aq[2] == 14'h3FFF) ir = 1'b0;
        // read value latched at the first read cycle, toggles when idle
        dq_i    <= rd[1] ? (rp[1] ? dq_i : rv(1)) : ~dq_i;
        r_rdata <= rd[2] ? (rp[2] ? r_rdata : rv(2)) : ~r_rdata;
        wp      <= wr;
        rp      <= rd;
    end
endmodule

`default_nettype wire

// file: bench/tb_top.sv
`default_nettype none

module tb_top
    import dpsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------
    logic        ref_clk = 1'b0;         // clock
    logic        sys_rst = 1'b1;         // reset
    logic        cmd_valid = 1'b0;       // command offered
    dpsm_op_t    cmd_op = DPSM_OP_MEM_RD; // command code
    logic [13:0] cmd_addr = '0;          // command address
    logic [7:0]  cmd_wdata = '0;         // command data
    logic        r_ce_n = 1'b1, r_sem_n = 1'b1, r_oe_n = 1'b1, r_rw_n = 1'b1; // right port
    logic [13:0] r_addr = '0, addr;      // addresses
    logic [7:0]  r_wdata = '0, r_rdata, dq_i, dq_o, rsp_rdata, got_d, q; // data
    logic        cmd_ready, rsp_valid, rsp_granted, mbox_flag, ce_n, sem_n, oe_n, rw_n;
    logic        dq_oe_n, busy_n, int_n, r_int_n, got_g; // pins and results
    int          err_total = 0, cmp_count = 0, lat; // counts, answer latency
    always #5 ref_clk = ~ref_clk;
    dpsm_host_port dut_u (.ref_clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata,
        .cmd_ready, .rsp_valid, .rsp_rdata, .rsp_granted, .mbox_flag, .ce_n, .sem_n, .oe_n,
        .rw_n, .addr, .dq_o, .dq_oe_n, .dq_i, .busy_n, .int_n);
    dpsm_dev_model model_u (.ref_clk, .ce_n, .sem_n, .oe_n, .rw_n, .addr, .l_dq(dq_o),
        .dq_oe_n, .dq_i, .busy_n, .int_n, .r_ce_n, .r_sem_n, .r_oe_n, .r_rw_n, .r_addr,
        .r_wdata, .r_rdata, .r_int_n);
    // ------------------------------------------------
    // compare, command and right-port tasks
    // ------------------------------------------------
    task automatic chk_bit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one command, held until taken; latency counted from the take
    task automatic run_cmd(input dpsm_op_t op, input logic [13:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_addr  = a;
        cmd_wdata = d;
        @(posedge ref_clk);
        while (cmd_ready !== 1'b1) @(posedge ref_clk);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        for (lat = 1; lat < 3000 && rsp_valid !== 1'b1; lat++) @(negedge ref_clk);
        chk_bit("answer arrived", 1'b1, rsp_valid);
        {got_d, got_g} = {rsp_rdata, rsp_granted};
    endtask
    // right processor access, strobes off two cycles after
    task automatic rp(input logic sm, input logic wr, input logic [13:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {r_ce_n, r_sem_n, r_addr, r_wdata} = {sm, !sm, a, d};
        repeat (2) @(negedge ref_clk);
        {r_rw_n, r_oe_n} = {!wr, wr};
        repeat (2) @(negedge ref_clk);
        q = r_rdata;
        {r_rw_n, r_oe_n, r_ce_n, r_sem_n} = 4'hF;
        repeat (2) @(negedge ref_clk);
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset;
        repeat (12) @(negedge ref_clk);
        chk_bit("cmd_ready in reset", 1'b0, cmd_ready);
        chk_bit("strobes in reset", 1'b1, ce_n & sem_n & dq_oe_n);
        sys_rst = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk_bit("cmd_ready after reset", 1'b1, cmd_ready);
        $display("test reset done");
    endtask
    task automatic t_sem;
        run_cmd(DPSM_OP_SEM_INIT, 14'h0000, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            rp(1'b1, 1'b0, 14'(i), 8'h00);
            chk_byte("free after init", 8'hFF, q);
        end
        run_cmd(DPSM_OP_SEM_ACQ, 14'h3FFB, 8'h00);
        chk_bit("granted", 1'b1, got_g);
        rp(1'b1, 1'b0, 14'h0003, 8'h00);
        chk_byte("other side sees taken", 8'hFF, q);
        rp(1'b1, 1'b1, 14'h0003, 8'hFE);
        rp(1'b1, 1'b0, 14'h0003, 8'h00);
        chk_byte("request while owned", 8'hFF, q);
        run_cmd(DPSM_OP_SEM_REL, 14'h0003, 8'h00);
        rp(1'b1, 1'b0, 14'h0003, 8'h00);
        chk_byte("pending wins on release", 8'h00, q);
        fork
            run_cmd(DPSM_OP_SEM_ACQ, 14'h0003, 8'h00);
            begin
                repeat (60) @(negedge ref_clk);
                rp(1'b1, 1'b1, 14'h0003, 8'h01);
            end
        join
        chk_bit("polled grant", 1'b1, got_g && lat > 60);
        rp(1'b1, 1'b0, 14'h0004, 8'h00);
        chk_byte("neighbour stays free", 8'hFF, q);
        $display("test semaphore done");
    endtask
    task automatic t_mbox;
        rp(1'b0, 1'b1, 14'h3FFE, 8'h5A);
        chk_bit("left flag set", 1'b1, mbox_flag);
        run_cmd(DPSM_OP_MBOX_READ, 14'h0000, 8'h00);
        chk_byte("left mailbox word", 8'h5A, got_d);
        repeat (3) @(negedge ref_clk);
        chk_bit("left flag cleared", 1'b0, mbox_flag);
        run_cmd(DPSM_OP_MBOX_POST, 14'h0000, 8'hC3);
        chk_bit("right flag pin", 1'b0, r_int_n);
        rp(1'b0, 1'b0, 14'h3FFF, 8'h00);
        chk_byte("right mailbox word", 8'hC3, q);
        chk_bit("right flag cleared", 1'b1, r_int_n);
        $display("test mailbox done");
    endtask
    task automatic t_busy;
        @(negedge ref_clk);
        {r_ce_n, r_addr} = {1'b0, 14'h0100};
        fork
            run_cmd(DPSM_OP_MEM_WR, 14'h0100, 8'h3C);
            begin
                repeat (40) @(negedge ref_clk);
                r_ce_n = 1'b1;
            end
        join
        chk_bit("write held while busy", 1'b1, lat > 35);
        run_cmd(DPSM_OP_MEM_RD, 14'h0100, 8'h00);
        chk_byte("read back", 8'h3C, got_d);
        rp(1'b0, 1'b0, 14'h0100, 8'h00);
        chk_byte("right sees write", 8'h3C, q);
        $display("test busy done");
    endtask
    // ------------------------------------------------
    // verdict, main sequence and watchdog
    // ------------------------------------------------
    task automatic close_out;
        $display("counts: %0d compared, %0d mismatched", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        t_reset();
        t_sem();
        t_mbox();
        t_busy();
        close_out();
    end
    // all tests need about 350 cycles; a hang ends the run
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        close_out();
    end
endmodule

`default_nettype wire
